// [verilog/gpvp_map.svh]
// Purpose: Register map and field layout of the eight-pin port slice.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Included by the port slice; definitions only.
//
// Overview of operation
// R1: Flag set when pin matches sense mode.
// R2: Writing one clears a flag; zero keeps.
// R3: Invert bit inverts both input and output.
// R4: Pull-up output follows pull-up control bit.
// R5: Code 0x0 keeps buffer, never flags.
// R6: 0x1 any edge, 0x2 rising, 0x3 falling.
// R7: 0x5 flags low level; 0x6, 0x7 reserved.
// R8: Code 0x4 disables buffer and sensing.
// R9: Disabled buffer: pin not sampled nor shown.
// R10: Virtual window mirrors direction, output, input, flags.
// R11: Writing one to input toggles output bit.
// R12: Input read shows levels of enabled pins.
// R13: Virtual flag needs source enable; one clears.
// R14: Direction one drives pin; zero is input.
// R15: Output one drives high, zero drives low.
// R16: Synchronised edges; set beats same-cycle clear.
// R17: Interrupt high while any enabled flag set.
`ifndef GPVP_MAP_SVH
`define GPVP_MAP_SVH

// ****************************************************************
// Full port register indices.
// ****************************************************************
`define GPVP_IDX_DIR        8'h00
`define GPVP_IDX_DIR_SET    8'h01
`define GPVP_IDX_DIR_CLR    8'h02
`define GPVP_IDX_DIR_TGL    8'h03
`define GPVP_IDX_OUT        8'h04
`define GPVP_IDX_OUT_SET    8'h05
`define GPVP_IDX_OUT_CLR    8'h06
`define GPVP_IDX_OUT_TGL    8'h07
`define GPVP_IDX_IN         8'h08
`define GPVP_IDX_FLAGS      8'h09
`define GPVP_IDX_PIN_CONTROL    8'h10
`define GPVP_IDX_PIN_CONTROL_LAST 8'h17

// ****************************************************************
// Interrupt enable, clear and status indices.
// ****************************************************************
`define GPVP_IDX_IRQ_EN     8'h18
`define GPVP_IDX_IRQ_CLR    8'h19
`define GPVP_IDX_IRQ_STAT   8'h1a

// ****************************************************************
// Virtual window indices: base plus 0x00 to 0x03.
// ****************************************************************
`define GPVP_IDX_VBASE      8'h20
`define GPVP_VOFS_DIR       8'h00
`define GPVP_VOFS_OUT       8'h01
`define GPVP_VOFS_IN        8'h02
`define GPVP_VOFS_FLAGS     8'h03

// ****************************************************************
// Reset values and bus responses.
// ****************************************************************
`define GPVP_RST_REG        8'h00
`define GPVP_RST_IRQ_EN     8'hff
`define GPVP_RESP_OKAY      2'h0
`define GPVP_RESP_SLVERR    2'h2

`endif

// [verilog/gpvp_pkg.sv]
// Purpose: Types shared by the port slice.
// Assumes: Field layout of one pin control byte.
// Notes:   No constants live here; see the map header.
`default_nettype none

package gpvp_pkg;

  // Input/sense selection codes of one pin.
  typedef enum logic [2:0] {
    GPVP_SENSE_OFF_BUF_ON = 3'h0,  // Buffer on, no events.
    GPVP_SENSE_ANY_EDGE   = 3'h1,  // Both edges.
    GPVP_SENSE_RISE       = 3'h2,  // Rising edge.
    GPVP_SENSE_FALL       = 3'h3,  // Falling edge.
    GPVP_SENSE_BUF_OFF    = 3'h4,  // Buffer disabled.
    GPVP_SENSE_LOW        = 3'h5,  // Low level.
    GPVP_SENSE_RSV6       = 3'h6,  // Reserved.
    GPVP_SENSE_RSV7       = 3'h7   // Reserved.
  } gpvp_sense_t;

  // One pin control byte.
  typedef struct packed {
    logic        invert_enable;   // Bit 7.
    logic [2:0]  unused;          // Bits 6:4, read zero.
    logic        pull_up_enable;  // Bit 3.
    gpvp_sense_t input_sense_select; // Bits 2:0.
  } gpvp_pin_ctrl_t;

endpackage : gpvp_pkg

`default_nettype wire

// [verilog/gpvp_port.sv]
// Purpose: Eight-pin port slice with sensing, flags and virtual window.
// Assumes: Pin inputs may be asynchronous; they are synchronised here.
// Notes:   AXI4-Lite slave; one write and one read in flight at most.
`include "gpvp_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gpvp_port #(
  parameter int NPIN = 8,   // Pins in the port.
  parameter int AW   = 10   // Byte address width.
) (
  input  wire logic            MCLK,
  input  wire logic            RESET_N,
  // AXI4-Lite write address channel.
  input  wire logic [AW-1:0]   S_AXI_AWADDR,
  input  wire logic            S_AXI_AWVALID,
  output logic                 S_AXI_AWREADY,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]     S_AXI_WDATA,
  input  wire logic [3:0]      S_AXI_WSTRB,
  input  wire logic            S_AXI_WVALID,
  output logic                 S_AXI_WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0]           S_AXI_BRESP,
  output logic                 S_AXI_BVALID,
  input  wire logic            S_AXI_BREADY,
  // AXI4-Lite read address channel.
  input  wire logic [AW-1:0]   S_AXI_ARADDR,
  input  wire logic            S_AXI_ARVALID,
  output logic                 S_AXI_ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0]          S_AXI_RDATA,
  output logic [1:0]           S_AXI_RRESP,
  output logic                 S_AXI_RVALID,
  input  wire logic            S_AXI_RREADY,
  // Port pins.
  input  wire logic [NPIN-1:0] PIN_I,
  output logic [NPIN-1:0]      PIN_O,
  output logic [NPIN-1:0]      PIN_OE,
  output logic [NPIN-1:0]      PIN_PULL_UP,
  // Port interrupt request.
  output logic                 IRQ
);

  // ********************
  // Storage.
  // ********************
  logic [NPIN-1:0]       dir;         // Direction, one is output.
  logic [NPIN-1:0]       out_val;     // Output value.
  logic [NPIN-1:0]       flags;       // Sticky pin event flags.
  logic [NPIN-1:0]       irq_en;      // Interrupt source enables.
  gpvp_pkg::gpvp_pin_ctrl_t ctrl [NPIN]; // Pin control bytes.

  // ********************
  // Pin sampling and sense results.
  // ********************
  logic [NPIN-1:0]       sync_a;      // First synchroniser stage.
  logic [NPIN-1:0]       sync_b;      // Second synchroniser stage.
  logic [NPIN-1:0]       sync_c;      // Previous settled sample.
  logic [NPIN-1:0]       buf_on;      // Input buffer enabled.
  logic [NPIN-1:0]       in_val;      // Input value as read.
  logic [NPIN-1:0]       event_hit;   // Sense match this cycle.
  logic [NPIN-1:0]       inv;         // Invert enables.

  // ********************
  // Bus slave state.
  // ********************
  logic                  aw_held;     // Write address captured.
  logic [7:0]            aw_idx;      // Captured register index.
  logic                  w_held;      // Write data captured.
  logic [7:0]            w_byte;      // Captured low data byte.
  logic                  w_lane;      // Low byte lane enabled.
  logic                  do_write;    // Perform the write now.
  logic                  wr_hit;      // Write index is mapped.
  logic [7:0]            ar_idx;      // Read index of request.
  logic [7:0]            rd_byte;     // Read mux result.
  logic                  rd_hit;      // Read index is mapped.

  // ********************
  // Write decode results.
  // ********************
  logic [NPIN-1:0]       next_dir;    // Direction after write.
  logic [NPIN-1:0]       next_out;    // Output after write.
  logic [NPIN-1:0]       flag_clr;    // Flags cleared by write.
  logic [7:0]            v_idx;       // Offset inside window.
  logic                  v_hit;       // Index inside window.

  // Channel readiness: one write and one read at a time.
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_write      = aw_held && w_held && !S_AXI_BVALID;
  assign ar_idx        = S_AXI_ARADDR[9:2];

  // Window offset of the captured write index.
  assign v_idx = aw_idx - `GPVP_IDX_VBASE;
  assign v_hit = (aw_idx >= `GPVP_IDX_VBASE) &&
                 (v_idx <= `GPVP_VOFS_FLAGS);

  // ********************
  // Pin outputs.
  // ********************

  // Drive enable, value with inversion, and pull-up per pin.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      inv[i]         = ctrl[i].invert_enable;
      PIN_OE[i]      = dir[i];                 // R14
      PIN_O[i]       = out_val[i] ^ inv[i];    // R15 R3
      PIN_PULL_UP[i] = ctrl[i].pull_up_enable; // R4
    end
  end

  // The request is high while an enabled flag is set.
  assign IRQ = |(flags & irq_en); // R17

  // ********************
  // Input synchroniser.
  // ********************

  // Two stages bring the pins into the clock domain; a third
  // keeps the prior sample for edge detection.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= PIN_I;   // R16
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // ********************
  // Per-pin sense logic.
  // ********************
  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
      logic lvl;       // Present level after inversion.
      logic lvl_prev;  // Previous level after inversion.
      logic rise;      // Rising transition seen.
      logic fall;      // Falling transition seen.

      assign lvl      = sync_b[g] ^ inv[g]; // R3
      assign lvl_prev = sync_c[g] ^ inv[g];
      assign rise     = lvl && !lvl_prev;   // R16
      assign fall     = !lvl && lvl_prev;
      assign buf_on[g] = ctrl[g].input_sense_select
                         != gpvp_pkg::GPVP_SENSE_BUF_OFF; // R8

      // A disabled buffer shows zero, not the pin.
      assign in_val[g] = buf_on[g] & lvl; // R9 R12

      // Match the selected sense mode.
      always_comb begin
        case (ctrl[g].input_sense_select)
          gpvp_pkg::GPVP_SENSE_OFF_BUF_ON: event_hit[g] = 1'b0;  // R5
          gpvp_pkg::GPVP_SENSE_ANY_EDGE:   event_hit[g] = rise | fall; // R6
          gpvp_pkg::GPVP_SENSE_RISE:       event_hit[g] = rise;  // R6
          gpvp_pkg::GPVP_SENSE_FALL:       event_hit[g] = fall;  // R6
          gpvp_pkg::GPVP_SENSE_BUF_OFF:    event_hit[g] = 1'b0;  // R8
          gpvp_pkg::GPVP_SENSE_LOW:        event_hit[g] = !lvl;  // R7
          default:                         event_hit[g] = 1'b0;  // R7
        endcase
      end
    end
  endgenerate

  // ********************
  // Write decode.
  // ********************

  // Work out the effect of the held write on direction, output
  // and flags. Virtual window writes act like full port writes, except that flag clears are masked by the enables.
  always_comb begin
    next_dir = dir;
    next_out = out_val;
    flag_clr = '0;
    wr_hit   = 1'b1;
    if (v_hit) begin
      // Virtual window.
      case (v_idx)
        `GPVP_VOFS_DIR:   next_dir = w_byte;           // R10
        `GPVP_VOFS_OUT:   next_out = w_byte;           // R10
        `GPVP_VOFS_IN:    next_out = out_val ^ w_byte; // R11
        `GPVP_VOFS_FLAGS: flag_clr = w_byte & irq_en;  // R13
        default:          wr_hit   = 1'b0;
      endcase
    end else begin
      // Full port registers.
      case (aw_idx)
        `GPVP_IDX_DIR:      next_dir = w_byte;            // R14
        `GPVP_IDX_DIR_SET:  next_dir = dir | w_byte;
        `GPVP_IDX_DIR_CLR:  next_dir = dir & ~w_byte;
        `GPVP_IDX_DIR_TGL:  next_dir = dir ^ w_byte;
        `GPVP_IDX_OUT:      next_out = w_byte;            // R15
        `GPVP_IDX_OUT_SET:  next_out = out_val | w_byte;
        `GPVP_IDX_OUT_CLR:  next_out = out_val & ~w_byte;
        `GPVP_IDX_OUT_TGL:  next_out = out_val ^ w_byte;
        `GPVP_IDX_IN:       next_out = out_val ^ w_byte;  // R11
        `GPVP_IDX_FLAGS:    flag_clr = w_byte;            // R2
        `GPVP_IDX_IRQ_CLR:  flag_clr = w_byte;            // R2
        `GPVP_IDX_IRQ_EN:   wr_hit   = 1'b1;
        default: begin
          // Pin control bytes sit in a block of eight.
          wr_hit = (aw_idx >= `GPVP_IDX_PIN_CONTROL) &&
                   (aw_idx <= `GPVP_IDX_PIN_CONTROL_LAST);
        end
      endcase
    end
  end

  // ********************
  // Direction and output registers.
  // ********************

  // Only the low byte lane carries register data.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      dir     <= `GPVP_RST_REG;
      out_val <= `GPVP_RST_REG;
    end else if (do_write && w_lane) begin
      dir     <= next_dir;
      out_val <= next_out;
    end
  end

  // ********************
  // Pin event flags.
  // ********************

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      flags <= `GPVP_RST_REG;
    end else if (do_write && w_lane) begin
      flags <= (flags & ~flag_clr) | event_hit; // R2 R16
    end else begin
      flags <= flags | event_hit;               // R1
    end
  end

  // ********************
  // Interrupt enables and pin control bytes.
  // ********************

  // Enables reset to all ones so any flag raises the request.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      irq_en <= `GPVP_RST_IRQ_EN;
    end else if (do_write && w_lane && !v_hit &&
                 aw_idx == `GPVP_IDX_IRQ_EN) begin
      irq_en <= w_byte;
    end
  end

  // Control bytes; bits 6:4 are not stored.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      for (int i = 0; i < NPIN; i++) begin
        ctrl[i] <= gpvp_pkg::gpvp_pin_ctrl_t'(`GPVP_RST_REG);
      end
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (do_write && w_lane && !v_hit &&
            aw_idx == `GPVP_IDX_PIN_CONTROL + 8'(i)) begin
          ctrl[i] <= gpvp_pkg::gpvp_pin_ctrl_t'(w_byte & 8'h8f);
        end
      end
    end
  end

  // ********************
  // Write channels.
  // ********************

  // Address and data are captured in either order; the write
  // happens once both are held, then the response is raised.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      aw_held <= 1'b0;
      aw_idx  <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_idx  <= S_AXI_AWADDR[9:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Data capture; only byte lane zero matters.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_byte <= S_AXI_WDATA[7:0];
      w_lane <= S_AXI_WSTRB[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped indices answer with an error.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `GPVP_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? `GPVP_RESP_OKAY : `GPVP_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ********************
  // Read mux.
  // ********************

  // Select the byte for a read index; unmapped reads give zero.
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (ar_idx)
      `GPVP_IDX_DIR,
      `GPVP_IDX_DIR_SET,
      `GPVP_IDX_DIR_CLR,
      `GPVP_IDX_DIR_TGL:  rd_byte = dir;
      `GPVP_IDX_OUT,
      `GPVP_IDX_OUT_SET,
      `GPVP_IDX_OUT_CLR,
      `GPVP_IDX_OUT_TGL:  rd_byte = out_val;
      `GPVP_IDX_IN:       rd_byte = in_val;             // R12
      `GPVP_IDX_FLAGS,
      `GPVP_IDX_IRQ_STAT: rd_byte = flags;
      `GPVP_IDX_IRQ_EN:   rd_byte = irq_en;
      `GPVP_IDX_IRQ_CLR:  rd_byte = 8'h00;
      `GPVP_IDX_VBASE + `GPVP_VOFS_DIR:   rd_byte = dir;     // R10
      `GPVP_IDX_VBASE + `GPVP_VOFS_OUT:   rd_byte = out_val; // R10
      `GPVP_IDX_VBASE + `GPVP_VOFS_IN:    rd_byte = in_val;  // R12
      `GPVP_IDX_VBASE + `GPVP_VOFS_FLAGS: rd_byte = flags & irq_en; // R13
      default: begin
        if (ar_idx >= `GPVP_IDX_PIN_CONTROL &&
            ar_idx <= `GPVP_IDX_PIN_CONTROL_LAST) begin
          rd_byte = ctrl[ar_idx[2:0]];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // ********************
  // Read channel.
  // ********************

  // Data is registered on the address handshake and held until
  // the master accepts it.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `GPVP_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h000000, rd_byte};
      S_AXI_RRESP  <= rd_hit ? `GPVP_RESP_OKAY : `GPVP_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule : gpvp_port

`default_nettype wire

// [verification/gpvp_port_props.sv]
// Purpose: Port-level timing checks of the port slice.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes:   Bound into every port slice instance below the module.
`timescale 1ns/1ps
`default_nettype none

module gpvp_port_props #(
  parameter int NPIN = 8  // Pins in the port.
) (
  input wire logic            MCLK,
  input wire logic            RESET_N,
  input wire logic            S_AXI_AWVALID,
  input wire logic            S_AXI_AWREADY,
  input wire logic            S_AXI_WVALID,
  input wire logic            S_AXI_WREADY,
  input wire logic            S_AXI_BVALID,
  input wire logic            S_AXI_BREADY,
  input wire logic            S_AXI_ARVALID,
  input wire logic            S_AXI_ARREADY,
  input wire logic [31:0]     S_AXI_RDATA,
  input wire logic            S_AXI_RVALID,
  input wire logic            S_AXI_RREADY,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic            IRQ
);
  // ********************
  // Bus steps and properties.
  // ********************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // Address and data of one write are both accepted at one edge.
  sequence s_write_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence

  // One read address is accepted.
  sequence s_read_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence

  a_write_answer_time: assert property (
    s_write_taken |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write response not on the second edge");
  a_read_answer_time: assert property (
    s_read_taken |=> S_AXI_RVALID)
    else $error("read data not on the next edge");
  a_bvalid_one_beat: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not released after acceptance");
  a_rvalid_one_beat: assert property (
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data not released after acceptance");
  a_write_ready_blocked: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while a response waits");
  a_read_ready_blocked: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while data waits");
  a_rdata_upper_zero: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  a_reset_quiet_state: assert property (
    disable iff (1'b0) !RESET_N |=> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ && ~|PIN_OE)
    else $error("outputs not quiet after a reset edge");
endmodule : gpvp_port_props

bind gpvp_port gpvp_port_props #(.NPIN(NPIN)) u_props (
  .MCLK(MCLK), .RESET_N(RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PIN_OE(PIN_OE), .IRQ(IRQ)
);

`default_nettype wire

// [verification/gpvp_pin_model.sv]
// Purpose: External circuitry on the eight port pins.
// Assumes: The bench picks which pins it drives and to what level.
// Notes:   A pin nobody drives wanders unless the pull-up holds it.
`timescale 1ns/1ps
`default_nettype none

module gpvp_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] ext_drive,
  output logic      [7:0] pin_i
);
  logic [7:0] wander = 8'h55;  // Changing level of a floating pin.

  // A floating line must not look like a stable level.
  always @(posedge clk) begin
    wander <= ~wander;
  end

  // The port driver wins, then the outside driver, then the pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_i[i] = pin_o[i];
      else if (ext_drive[i]) pin_i[i] = ext_level[i];
      else if (pin_pull_up[i]) pin_i[i] = 1'b1;
      else pin_i[i] = wander[i];
    end
  end
endmodule : gpvp_pin_model

`default_nettype wire

// [verification/gpvp_port_tb.sv]
// Purpose: Self-checking bench of the port slice.
// Assumes: Responses are always accepted at once by the bench.
// Notes:   Pins are read back through the external circuit model.
`include "gpvp_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gpvp_port_tb;
  localparam logic [1:0] OK  = `GPVP_RESP_OKAY;    // Good response.
  localparam logic [1:0] ERR = `GPVP_RESP_SLVERR;  // Unmapped response.
  localparam logic [7:0] V   = `GPVP_IDX_VBASE;    // Window base index.
  logic        mclk, reset_n, awvalid, wvalid, arvalid, bvalid, rvalid, irq;
  logic        awready, wready, arready;          // Slave readies.
  logic [9:0]  awaddr, araddr;                    // Byte addresses.
  logic [31:0] wdata, rdata;                      // Data buses.
  logic [1:0]  bresp, rresp;                      // Responses.
  logic [7:0]  pin_i, pin_o, pin_oe, pin_pu, ext_level, ext_drive;
  int          num_errors, comparisons, cycles;   // Tallies.

  gpvp_port dut (
    .MCLK(mclk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PULL_UP(pin_pu), .IRQ(irq));

  gpvp_pin_model u_pins (
    .clk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pull_up(pin_pu),
    .ext_level(ext_level), .ext_drive(ext_drive), .pin_i(pin_i));

  // ********************
  // Clock, watchdog and shared tasks.
  // ********************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // A hang is cut short and counted as a mismatch.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // Offers address and data together, drops each when taken, waits for the response.
  task automatic wr(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] exp);
    logic a, w;
    {a, w} = 2'h0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, data};
    {awvalid, wvalid} <= 2'h3;
    while (!(a && w)) begin
      @(negedge mclk);
      a = a | awready;
      w = w | wready;
      @(posedge mclk);
      awvalid <= !a;
      wvalid <= !w;
    end
    do @(negedge mclk); while (!bvalid);
    check({30'h0, bresp}, {30'h0, exp}, "write response");
    @(posedge mclk);
  endtask : wr

  // Issues one read and compares data and response.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er,
                    input string what);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do @(negedge mclk); while (!arready);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (!rvalid);
    check(rdata, {24'h0, exp}, what);
    check({30'h0, rresp}, {30'h0, er}, what);
    @(posedge mclk);
  endtask : rd

  // Lets a pin change pass the synchroniser and the flag stage.
  task automatic settle();
    repeat (5) @(posedge mclk);
  endtask : settle

  // ********************
  // Scenarios.
  // ********************
  task automatic t_reset_values();
    rd(`GPVP_IDX_DIR, 8'h00, OK, "dir reset");
    rd(`GPVP_IDX_FLAGS, 8'h00, OK, "flags reset");
    rd(`GPVP_IDX_PIN_CONTROL, 8'h00, OK, "control reset");
    rd(`GPVP_IDX_IRQ_EN, `GPVP_RST_IRQ_EN, OK, "enable reset");
    rd(8'h0a, 8'h00, ERR, "unmapped read");
    wr(8'h0a, 8'hff, ERR);
  endtask : t_reset_values

  task automatic t_pin_drive();
    wr(`GPVP_IDX_DIR, 8'hff, OK);
    wr(`GPVP_IDX_OUT, 8'ha5, OK);
    check({24'h0, pin_oe}, 32'hff, "drive enable");
    check({24'h0, pin_o}, 32'ha5, "drive level");
    wr(`GPVP_IDX_PIN_CONTROL, 8'h88, OK);
    check({24'h0, pin_o}, 32'ha4, "inverted drive");
    check({24'h0, pin_pu}, 32'h01, "pull-up");
    settle();
    rd(`GPVP_IDX_IN, 8'ha5, OK, "inverted input");
    wr(V + `GPVP_VOFS_IN, 8'h0f, OK);
    rd(V + `GPVP_VOFS_OUT, 8'haa, OK, "toggled output");
    wr(V + `GPVP_VOFS_DIR, 8'h00, OK);
    check({24'h0, pin_oe}, 32'h00, "window direction");
    wr(`GPVP_IDX_PIN_CONTROL, 8'h00, OK);
  endtask : t_pin_drive

  // Every sense code on pin two: a rise, a clear and a fall.
  task automatic t_sense_modes();
    for (int c = 0; c < 8; c++) begin
      wr(`GPVP_IDX_PIN_CONTROL + 8'h02, 8'(c), OK);
      settle();
      wr(`GPVP_IDX_FLAGS, 8'hff, OK);
      ext_level <= 8'h04;
      settle();
      rd(`GPVP_IDX_FLAGS, (c == 1 || c == 2 || c == 5) ? 8'h04 : 8'h00, OK, "rise");
      rd(`GPVP_IDX_IN, (c == 4) ? 8'h00 : 8'h04, OK, "input buffer");
      wr(`GPVP_IDX_FLAGS, 8'hff, OK);
      rd(`GPVP_IDX_FLAGS, 8'h00, OK, "cleared");
      ext_level <= 8'h00;
      settle();
      rd(`GPVP_IDX_FLAGS, (c == 1 || c == 3 || c == 5) ? 8'h04 : 8'h00, OK, "fall");
      check({31'h0, irq}, (c == 1 || c == 3 || c == 5) ? 32'h1 : 32'h0, "irq");
    end
    wr(`GPVP_IDX_PIN_CONTROL + 8'h02, 8'h00, OK);
    wr(`GPVP_IDX_FLAGS, 8'hff, OK);
  endtask : t_sense_modes

  // Partial clears, the enable mask and the window flag view.
  task automatic t_flags_irq();
    wr(`GPVP_IDX_PIN_CONTROL + 8'h03, 8'h02, OK);
    wr(`GPVP_IDX_PIN_CONTROL + 8'h04, 8'h02, OK);
    ext_level <= 8'h18;
    settle();
    rd(`GPVP_IDX_FLAGS, 8'h18, OK, "two flags");
    wr(`GPVP_IDX_FLAGS, 8'h08, OK);
    rd(`GPVP_IDX_IRQ_STAT, 8'h10, OK, "one cleared");
    wr(`GPVP_IDX_IRQ_EN, 8'h00, OK);
    check({31'h0, irq}, 32'h0, "masked irq");
    rd(V + `GPVP_VOFS_FLAGS, 8'h00, OK, "window masked");
    wr(`GPVP_IDX_IRQ_EN, 8'h10, OK);
    check({31'h0, irq}, 32'h1, "enabled irq");
    rd(V + `GPVP_VOFS_FLAGS, 8'h10, OK, "window flag");
    wr(V + `GPVP_VOFS_FLAGS, 8'h10, OK);
    rd(`GPVP_IDX_FLAGS, 8'h00, OK, "window clear");
    check({31'h0, irq}, 32'h0, "irq dropped");
    ext_level <= 8'h00;
    settle();
    ext_level <= 8'h08;
    settle();
    wr(`GPVP_IDX_IRQ_CLR, 8'h08, OK);
    rd(`GPVP_IDX_FLAGS, 8'h00, OK, "clear register");
    rd(`GPVP_IDX_IRQ_CLR, 8'h00, OK, "clear reads zero");
  endtask : t_flags_irq

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: reset for sixteen cycles, then each scenario.
  initial begin
    {awvalid, wvalid, arvalid, reset_n} = 4'h0;
    {awaddr, araddr, wdata} = 52'h0;
    {num_errors, comparisons, cycles} = 96'h0;
    ext_level = 8'h00;
    ext_drive = 8'hff;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset_values();
    t_pin_drive();
    t_sense_modes();
    t_flags_irq();
    print_verdict();
  end
endmodule : gpvp_port_tb

`default_nettype wire
